// ==== hw/fmsl_params.svh ====
`ifndef FMSL_PARAMS_SVH
`define FMSL_PARAMS_SVH

// bit counter values within one 9-clock unit
`define FMSL_CNT_ZERO 4'h0
`define FMSL_ACK_BIT 4'h8
`define FMSL_LAST_BIT 4'h9
`define FMSL_MSB_IDX 4'h7

// address word fields
`define FMSL_RW_POS 0
`define FMSL_RW_READ 1'b1

// memory shape
`define FMSL_ADDR_W 16
`define FMSL_DEPTH 65536

// reset value of the byte pointer
`define FMSL_PTR_RESET 16'h0000

`endif

// ==== hw/fmsl_pkg.sv ====
package fmsl_pkg;

  typedef enum logic [2:0] {
    ST_IDLE    = 3'b000,
    ST_DEVADDR = 3'b001,
    ST_ADDR_HI = 3'b010,
    ST_ADDR_LO = 3'b011,
    ST_WDATA   = 3'b100,
    ST_RDATA   = 3'b101,
    ST_WAIT    = 3'b110
  } fmsl_state_t;

  typedef struct packed {
    logic scl;
    logic sda;
    logic wp;
    logic [2:0] strap;
  } fmsl_pins_t;

endpackage

// ==== hw/fmsl_slave.sv ====
`timescale 1ns/1ns
`include "fmsl_params.svh"

// Operation
// - sample data on bus clock rise, change driven data only after a fall.
// - data changes only while clock low, except start and stop.
// - start is data falling while clock high; begins address word reception.
// - stop is data rising while clock high; ends transfer, back to standby.
// - receiver pulls data low on the ninth clock after each byte.
// - transmitter releases data on the ninth clock to sample acknowledge.
// - stop before the acknowledge bit abandons the operation, enters standby.
// - after a not-acknowledge the device releases the bus.
// - address word is type code, three address bits, direction flag.
// - top four bits compared with the fixed type code.
// - act only when the three address bits equal the strap pins.
// - an open strap pin counts as low.
// - write protect high blocks every memory write; low allows them.
// - reads work whatever the write protect level.
// - an open write protect pin counts as low, writes allowed.
// - after a write ends the device is ready at once.
// - data line driven open-drain only: pull low or release.
// - memory holds 65536 locations of eight bits.
// - address bits arrive after type code, strap 2 first.
// - eighth address bit zero means write, one means read.
// - type or address mismatch gives no acknowledge, back to standby.
module fmsl_slave
#(
  parameter logic [3:0] TYPE_CODE = 4'h5, // arbitrary value
  parameter int ADDR_W = `FMSL_ADDR_W,
  parameter int DEPTH = `FMSL_DEPTH
)
(
  input wire logic ref_clk,
  input wire logic reset,
  input wire logic scl_in,
  input wire logic sda_in,
  output logic sda_out,
  output logic sda_oe,
  input wire logic write_protect,
  input wire logic [2:0] address_strap_pins,
  output logic selected
);

  ////////////////////////////////////////////////////////////////////////
  // pin synchronisers and bus event detection

  fmsl_pkg::fmsl_pins_t meta;
  fmsl_pkg::fmsl_pins_t pin;
  fmsl_pkg::fmsl_pins_t prev;
  fmsl_pkg::fmsl_state_t state;
  logic [3:0] cnt;
  logic [7:0] rx;
  logic [7:0] tx;
  logic [7:0] addr_hi;
  logic [ADDR_W-1:0] ptr;
  logic [7:0] mem [DEPTH];
  logic scl_rise;
  logic scl_fall;
  logic start_det;
  logic stop_det;
  logic addr_match;
  logic active;
  logic mem_we;
  logic [7:0] rd_byte;

  // idle bus reads high on both lines
  always_ff @(posedge ref_clk or posedge reset)
  begin
    if (reset)
    begin
      meta <= 6'b110000;
      pin <= 6'b110000;
      prev <= 6'b110000;
    end
    else
    begin
      meta <= {scl_in, sda_in, write_protect, address_strap_pins};
      pin <= meta;
      prev <= pin;
    end
  end

  assign scl_rise = pin.scl & ~prev.scl;
  assign scl_fall = ~pin.scl & prev.scl;
  // data moving while clock stays high can only be start or stop
  assign start_det = pin.scl & prev.scl & prev.sda & ~pin.sda;
  assign stop_det = pin.scl & prev.scl & ~prev.sda & pin.sda;

  // pull-downs on the pad make open straps read low here
  assign addr_match = (rx[7:4] == TYPE_CODE)
    && (rx[3:1] == pin.strap);

  assign active = (state != fmsl_pkg::ST_IDLE)
    && (state != fmsl_pkg::ST_WAIT);

  assign rd_byte = mem[ptr];

  ////////////////////////////////////////////////////////////////////////
  // transfer sequencing

  always_ff @(posedge ref_clk or posedge reset)
  begin
    if (reset)
    begin
      state <= fmsl_pkg::ST_IDLE;
      cnt <= `FMSL_CNT_ZERO;
      rx <= 8'h00;
      tx <= 8'h00;
      addr_hi <= 8'h00;
      ptr <= `FMSL_PTR_RESET;
    end
    else if (stop_det)
    begin
      state <= fmsl_pkg::ST_IDLE;
      cnt <= `FMSL_CNT_ZERO;
    end
    else if (start_det)
    begin
      state <= fmsl_pkg::ST_DEVADDR;
      cnt <= `FMSL_CNT_ZERO;
    end
    else if (active && scl_rise)
    begin
      if (cnt < `FMSL_ACK_BIT)
      begin
        rx <= {rx[6:0], pin.sda};
        cnt <= cnt + 4'h1;
      end
      else if (cnt == `FMSL_ACK_BIT)
      begin
        cnt <= `FMSL_LAST_BIT;
        // master's not-acknowledge ends the read
        if (state == fmsl_pkg::ST_RDATA && pin.sda)
          state <= fmsl_pkg::ST_WAIT;
      end
    end
    else if (active && scl_fall)
    begin
      if (cnt == `FMSL_ACK_BIT)
      begin
        if (state == fmsl_pkg::ST_DEVADDR && !addr_match)
          state <= fmsl_pkg::ST_IDLE;
      end
      else if (cnt == `FMSL_LAST_BIT)
      begin
        cnt <= `FMSL_CNT_ZERO;
        case (state)
          fmsl_pkg::ST_DEVADDR:
          begin
            if (rx[`FMSL_RW_POS] == `FMSL_RW_READ)
            begin
              state <= fmsl_pkg::ST_RDATA;
              tx <= rd_byte;
              ptr <= ptr + 1'b1;
            end
            else
              state <= fmsl_pkg::ST_ADDR_HI;
          end
          fmsl_pkg::ST_ADDR_HI:
          begin
            addr_hi <= rx;
            state <= fmsl_pkg::ST_ADDR_LO;
          end
          fmsl_pkg::ST_ADDR_LO:
          begin
            ptr <= {addr_hi, rx};
            state <= fmsl_pkg::ST_WDATA;
          end
          fmsl_pkg::ST_WDATA:
            ptr <= ptr + 1'b1;
          fmsl_pkg::ST_RDATA:
          begin
            tx <= rd_byte;
            ptr <= ptr + 1'b1;
          end
          default:
            state <= fmsl_pkg::ST_IDLE;
        endcase
      end
    end
  end

  always_ff @(posedge ref_clk or posedge reset)
  begin
    if (reset)
      selected <= 1'b0;
    else
      selected <= active && (state != fmsl_pkg::ST_DEVADDR);
  end

  ////////////////////////////////////////////////////////////////////////
  // memory array; a byte lands on the acknowledge fall, so nothing
  // remains pending once the stop arrives

  assign mem_we = active && scl_fall && !start_det && !stop_det
    && (cnt == `FMSL_ACK_BIT) && (state == fmsl_pkg::ST_WDATA)
    && !pin.wp;

  always_ff @(posedge ref_clk)
  begin
    if (mem_we)
      mem[ptr] <= rx;
  end

  ////////////////////////////////////////////////////////////////////////
  // open-drain data drive

  assign sda_out = 1'b0;

  always_ff @(posedge ref_clk or posedge reset)
  begin
    if (reset)
      sda_oe <= 1'b0;
    else if (stop_det || start_det)
      sda_oe <= 1'b0;
    else if (active && scl_fall)
    begin
      if (cnt == `FMSL_ACK_BIT)
        // read data: release for the master's acknowledge
        sda_oe <= (state == fmsl_pkg::ST_DEVADDR && addr_match)
          || state == fmsl_pkg::ST_ADDR_HI
          || state == fmsl_pkg::ST_ADDR_LO
          || state == fmsl_pkg::ST_WDATA;
      else if (cnt == `FMSL_LAST_BIT)
        sda_oe <= ((state == fmsl_pkg::ST_DEVADDR
          && rx[`FMSL_RW_POS] == `FMSL_RW_READ)
          || state == fmsl_pkg::ST_RDATA) && !rd_byte[7];
      else if (state == fmsl_pkg::ST_RDATA)
        sda_oe <= !tx[3'(`FMSL_MSB_IDX - cnt)];
      else
        sda_oe <= 1'b0;
    end
    else if (!active)
      sda_oe <= 1'b0;
  end

  ////////////////////////////////////////////////////////////////////////
  // checks

  oe_open_drain_a: assert property (@(posedge ref_clk)
    disable iff (reset)
    sda_oe |-> sda_out == 1'b0)
    else $error("data line driven high");

  oe_on_fall_a: assert property (@(posedge ref_clk)
    disable iff (reset)
    $rose(sda_oe) |-> $past(scl_fall) && !pin.scl)
    else $error("data pulled low outside clock low phase");

  stop_standby_a: assert property (@(posedge ref_clk)
    disable iff (reset)
    stop_det |=> state == fmsl_pkg::ST_IDLE && !sda_oe)
    else $error("stop did not return to standby");

  start_restart_a: assert property (@(posedge ref_clk)
    disable iff (reset)
    start_det |=> state == fmsl_pkg::ST_DEVADDR
      && cnt == `FMSL_CNT_ZERO && !sda_oe)
    else $error("start did not restart address reception");

  addr_ack_a: assert property (@(posedge ref_clk)
    disable iff (reset)
    (state == fmsl_pkg::ST_DEVADDR && scl_fall && !start_det
      && !stop_det && cnt == `FMSL_ACK_BIT && addr_match)
    |=> sda_oe && state == fmsl_pkg::ST_DEVADDR)
    else $error("matching address not acknowledged");

  addr_nack_a: assert property (@(posedge ref_clk)
    disable iff (reset)
    (state == fmsl_pkg::ST_DEVADDR && scl_fall && !start_det
      && !stop_det && cnt == `FMSL_ACK_BIT && !addr_match)
    |=> !sda_oe && state == fmsl_pkg::ST_IDLE)
    else $error("mismatched address acknowledged");

  read_release_a: assert property (@(posedge ref_clk)
    disable iff (reset)
    (state == fmsl_pkg::ST_RDATA && scl_fall && !start_det
      && !stop_det && cnt == `FMSL_ACK_BIT)
    |=> !sda_oe [*2])
    else $error("data line held during master acknowledge");

  nack_release_a: assert property (@(posedge ref_clk)
    disable iff (reset)
    (state == fmsl_pkg::ST_RDATA && scl_rise && !start_det
      && !stop_det && cnt == `FMSL_ACK_BIT && pin.sda)
    |=> state == fmsl_pkg::ST_WAIT && !sda_oe)
    else $error("not-acknowledge did not release the bus");

  // watches the stored byte itself, so a stray write path is caught too
  wp_block_a: assert property (@(posedge ref_clk)
    disable iff (reset)
    (active && scl_fall && cnt == `FMSL_ACK_BIT
      && state == fmsl_pkg::ST_WDATA && pin.wp)
    |=> rd_byte == $past(rd_byte))
    else $error("write while protected");

  write_lands_a: assert property (@(posedge ref_clk)
    disable iff (reset)
    mem_we |=> rd_byte == $past(rx))
    else $error("written byte not stored");

  ptr_step_a: assert property (@(posedge ref_clk)
    disable iff (reset)
    (state == fmsl_pkg::ST_WDATA && scl_fall && !start_det
      && !stop_det && cnt == `FMSL_LAST_BIT)
    |=> ptr == $past(ptr) + 1'b1)
    else $error("pointer did not advance after a byte");

endmodule

// ==== bench/fmsl_master_model.sv ====
`timescale 1ns/1ns
module fmsl_master_model
(
  input wire logic ref_clk,
  input wire logic sda_line,
  output logic scl,
  output logic pull
);
  // quarter phase; each bit drops one cycle: 31 cycles, near 125 ns
  localparam int Q = 8;
  // only this model opens transfers and clocks the bus
  initial
  begin
    scl = 1'b1;
    pull = 1'b0;
  end
  task automatic tick(input int n);
    repeat (n) @(posedge ref_clk);
  endtask
  // data moves only while the clock is low
  task automatic put_bit(input logic b);
    tick(Q);
    pull <= ~b;
    tick(Q);
    scl <= 1'b1;
    tick(2 * Q - 1);
    scl <= 1'b0;
  endtask
  task automatic get_bit(output logic b);
    tick(Q);
    pull <= 1'b0;
    tick(Q);
    scl <= 1'b1;
    tick(Q);
    b = sda_line;
    tick(Q - 1);
    scl <= 1'b0;
  endtask
  // works from idle and as a repeated start
  task automatic start();
    tick(Q);
    pull <= 1'b0;
    tick(Q);
    scl <= 1'b1;
    tick(2 * Q);
    pull <= 1'b1;
    tick(2 * Q);
    scl <= 1'b0;
  endtask
  task automatic stop();
    tick(Q);
    pull <= 1'b1;
    tick(Q);
    scl <= 1'b1;
    tick(2 * Q);
    pull <= 1'b0;
    tick(2 * Q);
  endtask
  // msb first, line let go on the ninth clock
  task automatic put_byte(input logic [7:0] v, output logic ack);
    logic b;
    for (int i = 7; i >= 0; i--)
      put_bit(v[i]);
    get_bit(b);
    ack = ~b;
  endtask
  // low on the ninth clock goes on, high ends the read
  task automatic get_byte(input logic last, output logic [7:0] v);
    for (int i = 7; i >= 0; i--)
      get_bit(v[i]);
    put_bit(last);
  endtask
endmodule

// ==== bench/tb_top.sv ====
`timescale 1ns/1ns
module tb_top;
  localparam logic [3:0] TC = 4'h6; // arbitrary type code
  logic ref_clk, reset, wp, scl, pull, sda_out, sda_oe, selected;
  logic [2:0] strap;
  int err_count, checks_done;
  // pull-up: high unless someone pulls low
  wire logic sda_line = ~pull & (sda_oe ? sda_out : 1'b1);
  fmsl_slave #(.TYPE_CODE(TC)) i_fmsl_slave (.ref_clk(ref_clk),
    .reset(reset), .scl_in(scl), .sda_in(sda_line), .sda_out(sda_out),
    .sda_oe(sda_oe), .write_protect(wp), .address_strap_pins(strap),
    .selected(selected));
  fmsl_master_model i_master (.ref_clk(ref_clk), .sda_line(sda_line),
    .scl(scl), .pull(pull));
  ////////////////////////////////////////////////////////////////////////
  task automatic check_bit(input string n, input logic e, input logic g);
    checks_done++;
    if (g !== e)
    begin
      err_count++;
      $display("[ERR] %s expected %b seen %b", n, e, g);
    end
  endtask
  task automatic check_byte(input string n, input logic [7:0] e,
    input logic [7:0] g);
    checks_done++;
    if (g !== e)
    begin
      err_count++;
      $display("[ERR] %s expected %h seen %h", n, e, g);
    end
  endtask
  task automatic test_done();
    $display("checks %0d errors %0d", checks_done, err_count);
    if (err_count == 0 && checks_done > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask
  task automatic send(input logic [7:0] v, input logic e);
    logic a;
    i_master.put_byte(v, a);
    check_bit("ack", e, a);
  endtask
  task automatic header(input logic [15:0] a);
    i_master.start();
    send({TC, strap, 1'b0}, 1'b1);
    send(a[15:8], 1'b1);
    send(a[7:0], 1'b1);
  endtask
  task automatic read_at(input logic [15:0] a);
    header(a);
    i_master.start();
    send({TC, strap, 1'b1}, 1'b1);
  endtask
  task automatic read(input logic [7:0] e, input logic last);
    logic [7:0] v;
    i_master.get_byte(last, v);
    check_byte("rdata", e, v);
    if (last)
      check_bit("oe after nack", 1'b0, sda_oe);
  endtask
  ////////////////////////////////////////////////////////////////////////
  task automatic t_page_wrap();
    header(16'hffff);
    send(8'ha5, 1'b1);
    send(8'h3c, 1'b1);
    check_bit("selected", 1'b1, selected);
    check_bit("sda_out", 1'b0, sda_out);
    i_master.stop();
    check_bit("idle", 1'b0, selected);
    read_at(16'hffff);
    read(8'ha5, 1'b0);
    read(8'h3c, 1'b1);
    i_master.stop();
  endtask
  task automatic t_mismatch();
    logic [7:0] w [3];
    w = '{{TC ^ 4'h8, strap, 1'b0}, {TC, strap ^ 3'h4, 1'b0},
      {TC, strap ^ 3'h1, 1'b1}};
    foreach (w[i])
    begin
      i_master.start();
      send(w[i], 1'b0);
      send(8'h00, 1'b0);
      check_bit("unselected", 1'b0, selected);
      i_master.stop();
    end
  endtask
  task automatic t_protect();
    wp <= 1'b1;
    header(16'hffff);
    send(8'h00, 1'b1);
    i_master.stop();
    read_at(16'hffff);
    read(8'ha5, 1'b1);
    i_master.stop();
    wp <= 1'b0;
  endtask
  task automatic t_abort();
    strap <= 3'h0;
    i_master.start();
    send({TC, 3'h0, 1'b0}, 1'b1);
    i_master.put_bit(1'b1);
    i_master.put_bit(1'b0);
    read_at(16'h0000);
    read(8'h3c, 1'b1);
    header(16'h0000);
    i_master.put_bit(1'b0);
    i_master.put_bit(1'b1);
    i_master.stop();
    check_bit("abandon", 1'b0, selected);
    check_bit("abandon oe", 1'b0, sda_oe);
    read_at(16'h0000);
    read(8'h3c, 1'b1);
    i_master.stop();
  endtask
  ////////////////////////////////////////////////////////////////////////
  initial
  begin
    ref_clk = 1'b0;
    forever #2 ref_clk = ~ref_clk;
  end
  initial
  begin
    repeat (100000) @(posedge ref_clk);
    err_count++;
    $display("[ERR] run time expected end seen limit");
    test_done();
  end
  initial
  begin
    err_count = 0;
    checks_done = 0;
    reset = 1'b1;
    wp = 1'b0;
    // not a palindrome, so a reversed strap order cannot match
    strap = 3'h6;
    repeat (4) @(posedge ref_clk);
    reset <= 1'b0;
    repeat (8) @(posedge ref_clk);
    t_page_wrap();
    t_mismatch();
    t_protect();
    t_abort();
    test_done();
  end
endmodule
